/* kvf_params.svh */
// Constants of the key-vault host mailbox front end
`ifndef KVF_PARAMS_SVH
`define KVF_PARAMS_SVH

// Register byte offsets
`define KVF_OFF_STATUS 5'h00
`define KVF_OFF_INBOX 5'h04
`define KVF_OFF_OUTBOX 5'h08
`define KVF_OFF_STATRESP 5'h0c
`define KVF_OFF_CTRL 5'h10

// Status and control register fields
`define KVF_STS_WAITING_BIT 0
`define KVF_STS_DOUT_BUSY_BIT 1
`define KVF_STS_STAT_BUSY_BIT 2
`define KVF_STS_STATE_LSB 4
`define KVF_STS_DROPS_LSB 8
`define KVF_CTRL_FAULT_BIT 0

// Message layout: magic, kind, payload, xor check byte
`define KVF_MSG_MAGIC 4'ha
`define KVF_WIPE_CODE 16'h5a3c
`define KVF_RST_WORD 32'h0000_0000
`define KVF_RST_DROPS 8'h00

// Timing
`define KVF_CLK_PERIOD_NS 20
`define KVF_SELFTEST_NS 10000
`define KVF_ZEROIZE_NS 2000
`define KVF_SELFTEST_CYC ((`KVF_SELFTEST_NS + `KVF_CLK_PERIOD_NS - 1) / `KVF_CLK_PERIOD_NS)
`define KVF_ZEROIZE_CYC ((`KVF_ZEROIZE_NS + `KVF_CLK_PERIOD_NS - 1) / `KVF_CLK_PERIOD_NS)

`endif

/* kvf_pkg.sv */
// Types of the key-vault host mailbox front end
package kvf_pkg;
  typedef enum logic [2:0] {
    ST_SELFTEST = 3'h0,
    ST_APPROVED = 3'h1,
    ST_SLEEP = 3'h2,
    ST_ERROR = 3'h3,
    ST_ZEROIZE = 3'h4
  } kvf_state_t;
  typedef enum logic [3:0] {
    MSG_DATA = 4'h0,
    MSG_CTRL = 4'h1,
    MSG_WIPE = 4'h2,
    MSG_QUERY = 4'h3,
    MSG_REPLY = 4'h4
  } kvf_kind_t;
endpackage

/* kvf_sync_fall.sv */
// Two-flop synchroniser with falling-edge event
`timescale 1ns/1ps
module kvf_sync_fall #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic async_in,
  output logic level_out,
  output logic fall_out
);
  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic prev_q, prev_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
      prev_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // Edge taken between the second and third flop only
  assign level_out = sync_q;
  assign fall_out = prev_q & ~sync_q;
endmodule

/* kvf_front_end.sv */
// Host mailbox front end: serial link, mailboxes, control pins, register slave
`timescale 1ns/1ps
`include "kvf_params.svh"
module kvf_front_end
  import kvf_pkg::*;
#(
  parameter logic [15:0] SELFTEST_CYC = 16'(`KVF_SELFTEST_CYC),
  parameter logic [15:0] ZEROIZE_CYC = 16'(`KVF_ZEROIZE_CYC),
  parameter logic [15:0] WIPE_CODE = `KVF_WIPE_CODE
) (
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic RSTN_IN,
  // Register bus
  input wire logic [4:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  // Host serial link
  input wire logic LINK_CLK_IN,
  input wire logic REQ_SELECT_IN,
  input wire logic DATA_IN,
  output logic RECEIVE_READY_OUT,
  output logic DATA_OUT,
  output logic STATUS_OUT,
  output logic DATA_PENDING_OUT,
  output logic STATUS_PENDING_OUT,
  // Control and status pins
  input wire logic SLEEP_N_IN,
  input wire logic WIPE_N_IN,
  output logic MODE_OUT,
  output logic ERROR_OUT,
  output logic MSG_WAITING_OUT
);

  function automatic logic [31:0] mk_msg(input logic [3:0] kind, input logic [15:0] pay);
    logic [7:0] chk;
    chk = {`KVF_MSG_MAGIC, kind} ^ pay[15:8] ^ pay[7:0];
    return {`KVF_MSG_MAGIC, kind, pay, chk};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: receive shifter and two transmit shifters
  logic rtr_s;
  logic [1:0] req_s;
  logic [31:0] rx_sh_q, rx_sh_d;
  logic [4:0] rx_cnt_q, rx_cnt_d;
  logic [31:0] rx_word_q, rx_word_d;
  logic rx_tgl_q, rx_tgl_d;
  logic [31:0] tx_sh_q [2];
  logic [31:0] tx_sh_d [2];
  logic [4:0] tx_cnt_q [2];
  logic [4:0] tx_cnt_d [2];
  logic [1:0] ack_q, ack_d;
  logic [31:0] out_word_q [2];
  logic [31:0] out_word_d [2];
  logic [1:0] out_tgl_q, out_tgl_d;

  kvf_sync_fall #(.RST_VAL(1'b0)) u_rtr_sync (
    .clk_in(LINK_CLK_IN),
    .rstn_in(RSTN_IN),
    .async_in(RECEIVE_READY_OUT),
    .level_out(rtr_s),
    .fall_out()
  );

  for (genvar g = 0; g < 2; g++) begin : g_req_sync
    kvf_sync_fall #(.RST_VAL(1'b0)) u_req_sync (
      .clk_in(LINK_CLK_IN),
      .rstn_in(RSTN_IN),
      .async_in(out_tgl_q[g]),
      .level_out(req_s[g]),
      .fall_out()
    );
  end

  always_comb begin
    rx_sh_d = rx_sh_q;
    rx_cnt_d = rx_cnt_q;
    rx_word_d = rx_word_q;
    rx_tgl_d = rx_tgl_q;
    if (!REQ_SELECT_IN) begin
      // A frame cut short leaves no partial word behind
      rx_cnt_d = 5'h0;
    end else if (rtr_s) begin
      rx_sh_d = {rx_sh_q[30:0], DATA_IN};
      rx_cnt_d = rx_cnt_q + 5'h1;
      if (rx_cnt_q == 5'h1f) begin
        rx_word_d = {rx_sh_q[30:0], DATA_IN};
        rx_tgl_d = ~rx_tgl_q;
      end
    end
    for (int i = 0; i < 2; i++) begin
      tx_sh_d[i] = tx_sh_q[i];
      tx_cnt_d[i] = tx_cnt_q[i];
      ack_d[i] = ack_q[i];
      if (!REQ_SELECT_IN) begin
        if (tx_cnt_q[i] == 5'h0 && req_s[i] != ack_q[i]) begin
          // Outside zeroize, the word is stable in the core until the ack toggle returns
          tx_sh_d[i] = out_word_q[i];
          tx_cnt_d[i] = 5'h1;
          ack_d[i] = req_s[i];
        end else begin
          tx_sh_d[i] = {tx_sh_q[i][30:0], 1'b0};
          tx_cnt_d[i] = (tx_cnt_q[i] == 5'h0) ? 5'h0 : tx_cnt_q[i] + 5'h1;
        end
      end
    end
  end

  always_ff @(posedge LINK_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rx_sh_q <= `KVF_RST_WORD;
      rx_cnt_q <= 5'h0;
      rx_word_q <= `KVF_RST_WORD;
      rx_tgl_q <= 1'b0;
      ack_q <= 2'h0;
      for (int i = 0; i < 2; i++) begin
        tx_sh_q[i] <= `KVF_RST_WORD;
        tx_cnt_q[i] <= 5'h0;
      end
    end else begin
      rx_sh_q <= rx_sh_d;
      rx_cnt_q <= rx_cnt_d;
      rx_word_q <= rx_word_d;
      rx_tgl_q <= rx_tgl_d;
      ack_q <= ack_d;
      for (int i = 0; i < 2; i++) begin
        tx_sh_q[i] <= tx_sh_d[i];
        tx_cnt_q[i] <= tx_cnt_d[i];
      end
    end
  end

  assign DATA_OUT = tx_sh_q[0][31];
  assign STATUS_OUT = tx_sh_q[1][31];

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: crossings and pin events
  logic rx_tgl_s, sleep_evt, wipe_evt;
  logic [1:0] ack_s;

  kvf_sync_fall #(.RST_VAL(1'b0)) u_rx_sync (
    .clk_in(MCLK_IN),
    .rstn_in(RSTN_IN),
    .async_in(rx_tgl_q),
    .level_out(rx_tgl_s),
    .fall_out()
  );
  kvf_sync_fall #(.RST_VAL(1'b1)) u_sleep_sync (
    .clk_in(MCLK_IN),
    .rstn_in(RSTN_IN),
    .async_in(SLEEP_N_IN),
    .level_out(),
    .fall_out(sleep_evt)
  );
  kvf_sync_fall #(.RST_VAL(1'b1)) u_wipe_sync (
    .clk_in(MCLK_IN),
    .rstn_in(RSTN_IN),
    .async_in(WIPE_N_IN),
    .level_out(),
    .fall_out(wipe_evt)
  );
  for (genvar g = 0; g < 2; g++) begin : g_ack_sync
    kvf_sync_fall #(.RST_VAL(1'b0)) u_ack_sync (
      .clk_in(MCLK_IN),
      .rstn_in(RSTN_IN),
      .async_in(ack_q[g]),
      .level_out(ack_s[g]),
      .fall_out()
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Message check and register decode
  logic rx_seen_q, rx_seen_d;
  logic new_msg, fmt_ok, wipe_hit;
  logic [3:0] msg_kind;
  logic [15:0] msg_pay;
  logic bus_req, bus_done, rd_inbox, fault_wr;
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d, rd_mux;
  logic [1:0] busy;
  kvf_state_t state_q, state_d;
  logic [15:0] timer_q, timer_d;
  logic [31:0] inbox_q, inbox_d;
  logic full_q, full_d;
  logic [7:0] drops_q, drops_d;
  logic mode_q, err_q, rtr_q, wtg_q, dpend_q, spend_q;

  assign new_msg = rx_tgl_s != rx_seen_q;
  assign msg_kind = rx_word_q[27:24];
  assign msg_pay = rx_word_q[23:8];
  assign fmt_ok = rx_word_q[31:28] == `KVF_MSG_MAGIC && msg_kind <= MSG_QUERY &&
                  rx_word_q[7:0] == (rx_word_q[31:24] ^ msg_pay[15:8] ^ msg_pay[7:0]);
  assign wipe_hit = new_msg && fmt_ok && msg_kind == MSG_WIPE && msg_pay == WIPE_CODE;
  assign bus_req = AVS_READ_IN | AVS_WRITE_IN;
  assign bus_done = bus_req & ~wait_q;
  assign rd_inbox = bus_done & AVS_READ_IN & (AVS_ADDRESS_IN == `KVF_OFF_INBOX);
  assign fault_wr = bus_done & AVS_WRITE_IN & (AVS_ADDRESS_IN == `KVF_OFF_CTRL) &
                    AVS_WRITEDATA_IN[`KVF_CTRL_FAULT_BIT];
  assign busy = out_tgl_q ^ ack_s;

  always_comb begin
    rd_mux = 32'h0;
    unique case (AVS_ADDRESS_IN)
      `KVF_OFF_STATUS: begin
        rd_mux[`KVF_STS_WAITING_BIT] = full_q;
        rd_mux[`KVF_STS_DOUT_BUSY_BIT] = busy[0];
        rd_mux[`KVF_STS_STAT_BUSY_BIT] = busy[1];
        rd_mux[`KVF_STS_STATE_LSB +: 3] = state_q;
        rd_mux[`KVF_STS_DROPS_LSB +: 8] = drops_q;
      end
      `KVF_OFF_INBOX: rd_mux = inbox_q;
      default: rd_mux = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Device state
  always_comb begin
    state_d = state_q;
    timer_d = timer_q + 16'h1;
    unique case (state_q)
      ST_SELFTEST: begin
        if (fault_wr) begin
          state_d = ST_ERROR;
        end else if (timer_q == SELFTEST_CYC - 16'h1) begin
          state_d = ST_APPROVED;
        end
      end
      ST_APPROVED: begin
        if (fault_wr) begin
          state_d = ST_ERROR;
        end else if (sleep_evt) begin
          state_d = ST_SLEEP;
        end
      end
      ST_ERROR: begin
        if (sleep_evt) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (sleep_evt) begin
          state_d = ST_SELFTEST;
        end
      end
      ST_ZEROIZE: begin
        if (timer_q == ZEROIZE_CYC - 16'h1) begin
          state_d = ST_SLEEP;
        end
      end
      default: state_d = ST_ERROR;
    endcase
    if ((wipe_evt || wipe_hit) && state_q != ST_ZEROIZE) begin
      state_d = ST_ZEROIZE;
    end
    if (state_d != state_q) begin
      timer_d = 16'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mailboxes and bus handshake
  always_comb begin
    rx_seen_d = rx_tgl_s;
    inbox_d = inbox_q;
    // Clear on read first, so an arrival in the same cycle still lands
    full_d = full_q & ~rd_inbox;
    drops_d = drops_q;
    out_word_d = out_word_q;
    out_tgl_d = out_tgl_q;
    wait_d = 1'b1;
    rdata_d = rdata_q;
    if (bus_req && wait_q) begin
      wait_d = 1'b0;
      rdata_d = rd_mux;
    end
    if (new_msg) begin
      if (!fmt_ok || state_q != ST_APPROVED) begin
        drops_d = drops_q + 8'h1;
      end else begin
        case (msg_kind)
          MSG_DATA, MSG_CTRL: begin
            if (!full_d) begin
              inbox_d = rx_word_q;
              full_d = 1'b1;
            end else begin
              drops_d = drops_q + 8'h1;
            end
          end
          MSG_QUERY: begin
            if (!busy[1]) begin
              out_word_d[1] = mk_msg(MSG_REPLY, {13'h0, state_q});
              out_tgl_d[1] = ~out_tgl_q[1];
            end else begin
              drops_d = drops_q + 8'h1;
            end
          end
          default: begin
            if (!wipe_hit) begin
              drops_d = drops_q + 8'h1;
            end
          end
        endcase
      end
    end
    if (bus_done && AVS_WRITE_IN) begin
      if (AVS_ADDRESS_IN == `KVF_OFF_OUTBOX && !busy[0]) begin
        out_word_d[0] = AVS_WRITEDATA_IN;
        out_tgl_d[0] = ~out_tgl_q[0];
      end
      if (AVS_ADDRESS_IN == `KVF_OFF_STATRESP && !busy[1] && out_tgl_d[1] == out_tgl_q[1]) begin
        out_word_d[1] = AVS_WRITEDATA_IN;
        out_tgl_d[1] = ~out_tgl_q[1];
      end
    end
    if (state_q == ST_ZEROIZE || state_d == ST_ZEROIZE) begin
      // Words already in a link shifter still go out; the rest reads as zero
      inbox_d = `KVF_RST_WORD;
      full_d = 1'b0;
      out_word_d[0] = `KVF_RST_WORD;
      out_word_d[1] = `KVF_RST_WORD;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state_q <= ST_SELFTEST;
      timer_q <= 16'h0;
      rx_seen_q <= 1'b0;
      inbox_q <= `KVF_RST_WORD;
      full_q <= 1'b0;
      drops_q <= `KVF_RST_DROPS;
      out_word_q[0] <= `KVF_RST_WORD;
      out_word_q[1] <= `KVF_RST_WORD;
      out_tgl_q <= 2'h0;
      wait_q <= 1'b1;
      rdata_q <= `KVF_RST_WORD;
      mode_q <= 1'b0;
      err_q <= 1'b0;
      rtr_q <= 1'b0;
      wtg_q <= 1'b0;
      dpend_q <= 1'b0;
      spend_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      rx_seen_q <= rx_seen_d;
      inbox_q <= inbox_d;
      full_q <= full_d;
      drops_q <= drops_d;
      out_word_q <= out_word_d;
      out_tgl_q <= out_tgl_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      mode_q <= state_d == ST_APPROVED;
      err_q <= state_d == ST_ERROR;
      rtr_q <= state_d == ST_APPROVED && !full_d;
      wtg_q <= full_d;
      dpend_q <= out_tgl_d[0] ^ ack_s[0];
      spend_q <= out_tgl_d[1] ^ ack_s[1];
    end
  end

  assign AVS_READDATA_OUT = rdata_q;
  assign AVS_WAITREQUEST_OUT = wait_q;
  assign RECEIVE_READY_OUT = rtr_q;
  assign MODE_OUT = mode_q;
  assign ERROR_OUT = err_q;
  assign MSG_WAITING_OUT = wtg_q;
  assign DATA_PENDING_OUT = dpend_q;
  assign STATUS_PENDING_OUT = spend_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RSTN_IN);

  property p_mode_approved;
    MODE_OUT == (state_q == ST_APPROVED);
  endproperty
  a_mode_approved: assert property (p_mode_approved) else $error("mode pin wrong");

  property p_err_state;
    ERROR_OUT == (state_q == ST_ERROR);
  endproperty
  a_err_state: assert property (p_err_state) else $error("error pin wrong");

  property p_sleep_enter;
    (state_q == ST_APPROVED && sleep_evt && !wipe_evt && !wipe_hit && !fault_wr)
      |=> state_q == ST_SLEEP ##1 !MODE_OUT;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("no sleep on edge");

  property p_wake;
    (state_q == ST_SLEEP && sleep_evt && !wipe_evt && !wipe_hit) |=> state_q == ST_SELFTEST;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on edge");

  property p_wipe_pin;
    $fell(WIPE_N_IN) |-> ##[2:3] state_q == ST_ZEROIZE;
  endproperty
  a_wipe_pin: assert property (p_wipe_pin) else $error("wipe pin ignored");

  property p_wipe_msg;
    wipe_hit |=> state_q == ST_ZEROIZE && !full_q;
  endproperty
  a_wipe_msg: assert property (p_wipe_msg) else $error("wipe code ignored");

  property p_drop_bad;
    (new_msg && !fmt_ok) |=> drops_q == $past(drops_q) + 8'h1 && full_q == $past(full_q & ~rd_inbox);
  endproperty
  a_drop_bad: assert property (p_drop_bad) else $error("bad message kept");

  property p_store;
    (new_msg && fmt_ok && state_q == ST_APPROVED && msg_kind <= MSG_CTRL && !full_q)
      |=> MSG_WAITING_OUT && inbox_q == $past(rx_word_q) && !RECEIVE_READY_OUT;
  endproperty
  a_store: assert property (p_store) else $error("valid message not stored");

  property p_no_overwrite;
    (full_q && !rd_inbox && state_d != ST_ZEROIZE) |=> inbox_q == $past(inbox_q) && MSG_WAITING_OUT;
  endproperty
  a_no_overwrite: assert property (p_no_overwrite) else $error("unread message lost");

  property p_query;
    (new_msg && fmt_ok && state_q == ST_APPROVED && msg_kind == MSG_QUERY && !busy[1] && !wipe_evt)
      |=> out_word_q[1][10:8] == $past(state_q) ##2 STATUS_PENDING_OUT;
  endproperty
  a_query: assert property (p_query) else $error("state query unanswered");
endmodule

/* kvf_host_model.sv */
// Host-side model of the serial request and response links
`timescale 1ns/1ps
module kvf_host_model (
  // Link drive
  output logic link_clk_out,
  output logic req_select_out,
  output logic data_out,
  // Device links
  input wire logic dout_in,
  input wire logic sout_in
);
  logic [35:0] dcap;
  logic [35:0] scap;
  initial begin
    link_clk_out = 1'b0;
    req_select_out = 1'b0;
    data_out = 1'b1;
    dcap = '0;
    scap = '0;
  end
  ////////////////////////////////////////
  // Clock stands still outside frames
  task automatic pulse();
    #15 link_clk_out = 1'b1;
    #15 link_clk_out = 1'b0;
  endtask
  // Two idle rises first so the ready flag reaches the link side
  task automatic send(input logic [31:0] w);
    pulse();
    pulse();
    req_select_out = 1'b1;
    for (int i = 31; i >= 0; i--) begin
      data_out = w[i];
      pulse();
    end
    req_select_out = 1'b0;
    // Released line flips so a stale bit never looks valid
    data_out = ~data_out;
  endtask
  task automatic recv();
    for (int i = 0; i < 36; i++) begin
      pulse();
      dcap = {dcap[34:0], dout_in};
      scap = {scap[34:0], sout_in};
    end
  endtask
endmodule

/* kvf_front_end_tb.sv */
// Self-checking bench for the key-vault host mailbox front end
`timescale 1ns/1ps
`include "kvf_params.svh"
module kvf_front_end_tb
  import kvf_pkg::*;
;
  localparam logic [15:0] ZC = 16'h0020;
  localparam int S_MODE = 4, S_ERR = 3, S_WAIT = 2, S_DP = 1, S_SP = 0;
  logic MCLK_IN, RSTN_IN, AVS_READ_IN, AVS_WRITE_IN, AVS_WAITREQUEST_OUT;
  logic [4:0] AVS_ADDRESS_IN;
  logic [31:0] AVS_WRITEDATA_IN, AVS_READDATA_OUT;
  logic LINK_CLK_IN, REQ_SELECT_IN, DATA_IN, RECEIVE_READY_OUT, DATA_OUT, STATUS_OUT;
  logic DATA_PENDING_OUT, STATUS_PENDING_OUT, SLEEP_N_IN, WIPE_N_IN;
  logic MODE_OUT, ERROR_OUT, MSG_WAITING_OUT;
  logic [7:0] drops;
  int num_errors;
  int compares;
  wire [4:0] sigs = {MODE_OUT, ERROR_OUT, MSG_WAITING_OUT, DATA_PENDING_OUT, STATUS_PENDING_OUT};
  kvf_front_end #(.SELFTEST_CYC(16'h0004), .ZEROIZE_CYC(ZC)) dut (
    .MCLK_IN(MCLK_IN), .RSTN_IN(RSTN_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN),
    .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
    .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT),
    .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .LINK_CLK_IN(LINK_CLK_IN),
    .REQ_SELECT_IN(REQ_SELECT_IN), .DATA_IN(DATA_IN), .RECEIVE_READY_OUT(RECEIVE_READY_OUT),
    .DATA_OUT(DATA_OUT), .STATUS_OUT(STATUS_OUT), .DATA_PENDING_OUT(DATA_PENDING_OUT),
    .STATUS_PENDING_OUT(STATUS_PENDING_OUT), .SLEEP_N_IN(SLEEP_N_IN), .WIPE_N_IN(WIPE_N_IN),
    .MODE_OUT(MODE_OUT), .ERROR_OUT(ERROR_OUT), .MSG_WAITING_OUT(MSG_WAITING_OUT)
  );
  kvf_host_model host (
    .link_clk_out(LINK_CLK_IN), .req_select_out(REQ_SELECT_IN), .data_out(DATA_IN),
    .dout_in(DATA_OUT), .sout_in(STATUS_OUT)
  );
  initial begin
    MCLK_IN = 1'b0;
    forever #10 MCLK_IN = ~MCLK_IN;
  end
  ////////////////////////////////////////
  task automatic summarize();
    if (num_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic fail(input string what);
    num_errors++;
    $display("mismatch at %0t: timeout on %s", $time, what);
    summarize();
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    logic ok;
    AVS_ADDRESS_IN <= a;
    AVS_WRITE_IN <= wr;
    AVS_READ_IN <= ~wr;
    AVS_WRITEDATA_IN <= wd;
    ok = 1'b0;
    rd = 32'h0;
    // Sampled mid-cycle, so the next rise is the one that sees it low
    for (int n = 0; n < 50 && !ok; n++) begin
      @(negedge MCLK_IN);
      ok = (AVS_WAITREQUEST_OUT === 1'b0);
      rd = AVS_READDATA_OUT;
      @(posedge MCLK_IN);
    end
    AVS_READ_IN <= 1'b0;
    AVS_WRITE_IN <= 1'b0;
    @(posedge MCLK_IN);
    if (!ok) fail("waitrequest");
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(r, exp);
  endtask
  task automatic wait_for(input int idx, input logic val);
    int n;
    for (n = 0; n < 400 && sigs[idx] !== val; n++) @(posedge MCLK_IN);
    if (n == 400) fail("status pin");
  endtask
  // Crossing into the core takes a few core cycles
  task automatic snd(input logic [31:0] w);
    host.send(w);
    repeat (10) @(posedge MCLK_IN);
  endtask
  task automatic wake();
    SLEEP_N_IN <= 1'b0;
    wait_for(S_MODE, 1'b1);
    SLEEP_N_IN <= 1'b1;
    repeat (6) @(posedge MCLK_IN);
  endtask
  function automatic logic [31:0] mk(input logic [3:0] k, input logic [15:0] p);
    logic [23:0] h;
    h = {`KVF_MSG_MAGIC, k, p};
    return {h, h[23:16] ^ h[15:8] ^ h[7:0]};
  endfunction
  function automatic logic [31:0] st(input kvf_state_t s);
    return {16'h0, drops, 1'b0, s, 4'h0};
  endfunction
  // Load may come a rise or two early when pending was already seen
  function automatic logic [31:0] on_link(input logic [35:0] cap, input logic [31:0] w);
    logic [35:0] e;
    e = {4'h0, w};
    return 32'((cap == e << 2) || (cap == e << 3) || (cap == e << 4));
  endfunction
  ////////////////////////////////////////
  task automatic t_boot();
    check(32'(MODE_OUT), 32'h0);
    check(32'(ERROR_OUT), 32'h0);
    wait_for(S_MODE, 1'b1);
    rdchk(`KVF_OFF_STATUS, st(ST_APPROVED));
    rdchk(5'h14, 32'h0);
    rdchk(`KVF_OFF_OUTBOX, 32'h0);
  endtask
  task automatic t_inbox();
    logic [31:0] m1;
    m1 = mk(MSG_DATA, 16'h1234);
    snd(m1);
    wait_for(S_WAIT, 1'b1);
    check(32'(RECEIVE_READY_OUT), 32'h0);
    snd(mk(MSG_CTRL, 16'hbeef));
    check(32'(MSG_WAITING_OUT), 32'h1);
    rdchk(`KVF_OFF_INBOX, m1);
    check(32'(MSG_WAITING_OUT), 32'h0);
    rdchk(`KVF_OFF_STATUS, st(ST_APPROVED));
  endtask
  task automatic t_bad();
    logic [31:0] bad [4];
    bad[0] = mk(MSG_DATA, 16'h0001) ^ 32'h5000_0050;
    bad[1] = mk(MSG_DATA, 16'h0002) ^ 32'h0000_0001;
    bad[2] = mk(4'h5, 16'h0003);
    bad[3] = mk(MSG_WIPE, ~`KVF_WIPE_CODE);
    foreach (bad[i]) begin
      snd(bad[i]);
      drops++;
    end
    check(32'(MSG_WAITING_OUT), 32'h0);
    rdchk(`KVF_OFF_STATUS, st(ST_APPROVED));
  endtask
  task automatic t_links();
    wr(`KVF_OFF_OUTBOX, 32'h1234_5678);
    wr(`KVF_OFF_STATRESP, 32'h0bad_cafe);
    wait_for(S_SP, 1'b1);
    check(32'(DATA_PENDING_OUT), 32'h1);
    host.recv();
    check(on_link(host.dcap, 32'h1234_5678), 32'h1);
    check(on_link(host.scap, 32'h0bad_cafe), 32'h1);
    wait_for(S_DP, 1'b0);
    snd(mk(MSG_QUERY, 16'h0000));
    wait_for(S_SP, 1'b1);
    host.recv();
    check(on_link(host.scap, mk(MSG_REPLY, {13'h0, ST_APPROVED})), 32'h1);
    check(on_link(host.dcap, 32'h0), 32'h1);
  endtask
  task automatic t_sleep();
    SLEEP_N_IN <= 1'b0;
    repeat (12) @(posedge MCLK_IN);
    check(32'(MODE_OUT), 32'h0);
    rdchk(`KVF_OFF_STATUS, st(ST_SLEEP));
    SLEEP_N_IN <= 1'b1;
    repeat (6) @(posedge MCLK_IN);
    rdchk(`KVF_OFF_STATUS, st(ST_SLEEP));
    SLEEP_N_IN <= 1'b0;
    repeat (6) @(posedge MCLK_IN);
    check(32'(MODE_OUT), 32'h0);
    wake();
  endtask
  task automatic t_error();
    wr(`KVF_OFF_CTRL, 32'h1);
    wait_for(S_ERR, 1'b1);
    check(32'(MODE_OUT), 32'h0);
    rdchk(`KVF_OFF_STATUS, st(ST_ERROR));
    SLEEP_N_IN <= 1'b0;
    wait_for(S_ERR, 1'b0);
    rdchk(`KVF_OFF_STATUS, st(ST_SLEEP));
    SLEEP_N_IN <= 1'b1;
    repeat (6) @(posedge MCLK_IN);
    wake();
  endtask
  task automatic t_wipe();
    snd(mk(MSG_DATA, 16'h55aa));
    wait_for(S_WAIT, 1'b1);
    WIPE_N_IN <= 1'b0;
    repeat (6) @(posedge MCLK_IN);
    check(32'(MODE_OUT), 32'h0);
    check(32'(MSG_WAITING_OUT), 32'h0);
    rdchk(`KVF_OFF_STATUS, st(ST_ZEROIZE));
    WIPE_N_IN <= 1'b1;
    repeat (40) @(posedge MCLK_IN);
    rdchk(`KVF_OFF_STATUS, st(ST_SLEEP));
    wake();
    snd(mk(MSG_WIPE, `KVF_WIPE_CODE));
    wait_for(S_MODE, 1'b0);
    rdchk(`KVF_OFF_STATUS, st(ST_ZEROIZE));
  endtask
  ////////////////////////////////////////
  initial begin
    RSTN_IN = 1'b0;
    AVS_ADDRESS_IN = 5'h00;
    AVS_READ_IN = 1'b0;
    AVS_WRITE_IN = 1'b0;
    AVS_WRITEDATA_IN = 32'h0;
    SLEEP_N_IN = 1'b1;
    WIPE_N_IN = 1'b1;
    num_errors = 0;
    compares = 0;
    drops = 8'h00;
    host.pulse();
    host.pulse();
    repeat (4) @(posedge MCLK_IN);
    RSTN_IN <= 1'b1;
    t_boot();
    t_inbox();
    t_bad();
    t_links();
    t_sleep();
    t_error();
    t_wipe();
    summarize();
  end
endmodule
